/* hdl/cfr_regctl.sv */
/*
 * Register control of a 32-tap cascadable transversal filter: the two
 * coefficient banks and their swap, static configuration, input word,
 * result words, cycle start strobe and output multiplexing.
 * Assumes every pin is synchronous to clock; the host port acts like a
 * static RAM whose write commits on the rising edge of ce_n.
 */
// Function
// [R1] Active bank readable always, writable when idle
// [R2] Entry 0 feeds tap nearest output
// [R3] Update bank unused by arithmetic, always writable
// [R4] Swap exchanges both banks completely
// [R5] Configuration never changed by device, readable
// [R6] Host settles 20 cycles after reconfiguring
// [R7] Master drives strobe on input word write
// [R8] Input word register is write only
// [R9] Low result word: low 16 of sign-extended result
// [R10] High word: upper 8 bits plus sign
// [R11] Bit 10 selects normal or fast output
// [R12] Normal mode: equal low and high halves
// [R13] Four-bit size: fast equals normal
// [R14] Bits 9:8 set width and interval
// [R15] Coefficient taken from low register bits
// [R16] Host keeps size, mux, field during processing
// [R17] Reserved configuration bits, host writes zero
// [R18] Bits 5:4 pick rounded 24-bit field
// [R19] Bit 2 selects continuous or single swap
// [R20] Host avoids continuous swap with request pending
// [R21] Swap request runs at cycle end, self-clears
// [R22] Bit 1 selects pins or input word
// [R23] Host never mixes master with pin source
// [R24] Slave samples strobe one cycle early
module cfr_regctl
   import cfr_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic ce_n,
   input wire logic w_n,
   input wire logic [6:0] adr,
   input wire logic [15:0] d_i,
   output logic [15:0] d_o,
   output logic d_oe,
   input wire logic go_i,
   output logic go_o,
   output logic go_oe,
   input wire logic [15:0] din,
   input wire logic [11:0] cascade_input_pins,
   output logic [11:0] dout,
   output logic result_half_marker,
   output logic busy
);

   typedef struct packed {
      logic [CFR_TAPS-1:0][15:0] update_coefficient_bank;
      logic [CFR_TAPS-1:0][15:0] active_coefficient_bank;
      logic [CFR_TAPS-1:0][15:0] hist;
      logic [CFR_TAPS-1:0][23:0] casd;
      logic [15:0] static_configuration;
      logic [1:0] err;
      logic swap_req;
      logic [2:0] test_control;
      logic [15:0] dir;
      logic [15:0] result_low_word;
      logic [15:0] result_high_word;
      logic [11:0] cas_lo;
      logic [3:0] cnt;
      logic go_seen;
      logic go_drv;
      logic go_oe;
      cfr_out_t oph;
      logic [3:0] half_cnt;
      logic [23:0] res;
      logic [11:0] dout;
      logic marker;
      logic busy;
      logic ce_q;
      logic cs_q;
      logic w_q;
      logic [6:0] adr_q;
      logic [15:0] dat_q;
      logic [15:0] rd_data;
      logic rd_oe;
   } cfr_state_t;

   cfr_state_t st_r;
   cfr_state_t st_nxt;
   logic signed [36:0] acc;

   cfr_mac u_mac (
      .coef (st_r.active_coefficient_bank),
      .hist (st_r.hist),
      .csize (st_r.static_configuration[CFR_SCR_SIZE_LO +: 2]),
      .acc (acc)
   );

   function automatic logic [3:0] interval(input logic [1:0] sz);
      case (sz)
         2'b00: interval = CFR_IVL_4;
         2'b01: interval = CFR_IVL_8;
         2'b10: interval = CFR_IVL_12;
         default: interval = CFR_IVL_16;
      endcase
   endfunction : interval

   function automatic logic [5:0] field_pos(input logic [1:0] sel,
                                            input logic full);
      if (full) begin
         field_pos = CFR_POS_FULL;
      end else begin
         case (sel)
            2'b00: field_pos = CFR_POS_00;
            2'b01: field_pos = CFR_POS_01;
            2'b10: field_pos = CFR_POS_10;
            default: field_pos = CFR_POS_11;
         endcase
      end
   endfunction : field_pos

   // Working variables of the next-state process
   logic [44:0] ext;
   logic [5:0] pos;
   logic [23:0] sel;
   logic [23:0] sum;
   logic [3:0] ivl;
   logic [3:0] low_len;
   logic go_lvl;
   logic take;
   logic cyc_end;
   logic idle;
   logic do_swap;
   logic wr;
   logic [6:0] wa;
   logic [6:0] ra;
   logic [15:0] rd;
   logic [15:0] sample;

   always_comb begin
      st_nxt = st_r;
      ext = '0;
      pos = '0;
      sel = '0;
      sum = '0;
      rd = '0;
      ivl = interval(st_r.static_configuration[CFR_SCR_SIZE_LO +: 2]); // see [R14]
      // Fast mode shortens the low half; with 4-bit size the interval
      // is two, so both modes give one cycle per half
      if (st_r.static_configuration[CFR_SCR_FAST]) begin
         low_len = CFR_FAST_LOW; // see [R11] see [R13]
      end else begin
         low_len = {1'b0, ivl[3:1]}; // see [R12]
      end
      go_lvl = st_r.static_configuration[CFR_SCR_MASTER] ? st_r.go_drv : go_i;
      take = st_r.go_seen;
      cyc_end = (st_r.cnt == 4'h1);
      idle = (st_r.cnt == 4'h0) && !take;
      sample = st_r.static_configuration[CFR_SCR_SRC] ? st_r.dir : din; // see [R22]

      // Host port: capture while enabled, commit when ce_n rises
      wr = st_r.ce_q == 1'b0 && ce_n && !st_r.cs_q && !st_r.w_q;
      wa = st_r.adr_q;
      st_nxt.ce_q = ce_n;
      if (!ce_n) begin
         st_nxt.cs_q = cs_n;
         st_nxt.w_q = w_n;
         st_nxt.adr_q = adr;
         st_nxt.dat_q = d_i;
      end

      // Cycle counter and strobe sampling from one cycle before ready
      if (st_r.cnt != 4'h0) begin
         st_nxt.cnt = st_r.cnt - 4'h1;
      end
      if (!st_r.go_seen && st_r.cnt <= 4'h2 && go_lvl) begin
         st_nxt.go_seen = 1'b1; // see [R24]
      end
      if (take) begin
         st_nxt.hist = {st_r.hist[CFR_TAPS-2:0], sample};
         st_nxt.cnt = ivl;
         st_nxt.go_seen = 1'b0;
         st_nxt.go_drv = 1'b0;
      end

      // Result: pick field, round, add delayed cascade word
      ext = {{7{acc[36]}}, acc, 1'b0};
      pos = field_pos(st_r.static_configuration[CFR_SCR_SEL_LO +: 2],
                      st_r.test_control[CFR_TCR_FULL]);
      sel = ext[pos +: 24];
      if (pos != CFR_POS_FULL) begin
         sel = sel + {23'h0, ext[pos - 6'h1]}; // see [R18]
      end
      sum = sel + st_r.casd[CFR_TAPS-1];
      if (cyc_end) begin
         st_nxt.res = sum;
         st_nxt.casd = {st_r.casd[CFR_TAPS-2:0],
                        cascade_input_pins, st_r.cas_lo};
         st_nxt.dout = sum[11:0];
         st_nxt.marker = 1'b0;
         st_nxt.oph = CFR_OUT_LOW;
         st_nxt.half_cnt = low_len;
      end else if (st_r.oph == CFR_OUT_LOW) begin
         if (st_r.half_cnt <= 4'h1) begin
            // High half holds until the next output sequence
            st_nxt.oph = CFR_OUT_HIGH;
            st_nxt.dout = st_r.res[23:12];
            st_nxt.marker = 1'b1;
            st_nxt.cas_lo = cascade_input_pins;
            st_nxt.result_low_word = st_r.res[15:0]; // see [R9]
            st_nxt.result_high_word = {{8{st_r.res[23]}}, st_r.res[23:16]}; // see [R10]
         end else begin
            st_nxt.half_cnt = st_r.half_cnt - 4'h1;
         end
      end

      // Bank swap at cycle end, or at once when idle
      do_swap = (st_r.swap_req && (cyc_end || idle)) ||
                (st_r.static_configuration[CFR_SCR_CONT] && cyc_end); // see [R19] see [R21]
      st_nxt.busy = do_swap;
      if (do_swap) begin
         st_nxt.active_coefficient_bank = st_r.update_coefficient_bank; // see [R4]
         st_nxt.update_coefficient_bank = st_r.active_coefficient_bank;
         st_nxt.swap_req = 1'b0; // see [R21]
      end

      // Register writes; a fresh swap request beats the clear
      if (wr) begin
         if (wa < CFR_ADR_CCR0) begin
            st_nxt.update_coefficient_bank[wa[4:0]] = st_r.dat_q; // see [R3]
         end else if (wa[6] == 1'b0) begin
            // Writes while processing are the host's risk
            st_nxt.active_coefficient_bank[wa[4:0]] = st_r.dat_q; // see [R1]
         end else begin
            case (wa & CFR_ADR_SHADOW_MASK)
               CFR_ADR_SCR: st_nxt.static_configuration = st_r.dat_q;
               CFR_ADR_ACR: begin
                  st_nxt.err = st_r.dat_q[CFR_ACR_ERR_LO +: 2];
                  if (st_r.dat_q[CFR_ACR_SWAP]) begin
                     st_nxt.swap_req = 1'b1; // see [R21]
                  end
               end
               CFR_ADR_TCR: st_nxt.test_control = st_r.dat_q[2:0];
               CFR_ADR_DIR: begin
                  st_nxt.dir = st_r.dat_q;
                  if (st_r.static_configuration[CFR_SCR_MASTER]) begin
                     st_nxt.go_drv = 1'b1; // see [R7]
                  end
               end
               default: ;
            endcase
         end
      end
      st_nxt.go_oe = st_nxt.static_configuration[CFR_SCR_MASTER];

      // Read path: one cycle behind the address
      ra = adr;
      if (ra < CFR_ADR_CCR0) begin
         rd = st_r.update_coefficient_bank[ra[4:0]];
      end else if (ra[6] == 1'b0) begin
         rd = st_r.active_coefficient_bank[ra[4:0]]; // see [R1]
      end else begin
         case (ra & CFR_ADR_SHADOW_MASK)
            CFR_ADR_SCR: rd = st_r.static_configuration; // see [R5] see [R17]
            CFR_ADR_ACR: rd = {13'h0, st_r.err, st_r.swap_req};
            CFR_ADR_TCR: rd = {13'h0, st_r.test_control};
            CFR_ADR_DIR: rd = 16'h0000; // see [R8]
            CFR_ADR_DOL: rd = st_r.result_low_word;
            CFR_ADR_DOH: rd = st_r.result_high_word;
            default: rd = 16'h0000;
         endcase
      end
      st_nxt.rd_data = rd;
      st_nxt.rd_oe = !ce_n && !cs_n && w_n;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st_r <= '0;
         st_r.static_configuration <= CFR_SCR_RESET;
         st_r.ce_q <= 1'b1;
         st_r.cs_q <= 1'b1;
         st_r.w_q <= 1'b1;
         st_r.oph <= CFR_OUT_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign d_o = st_r.rd_data;
   assign d_oe = st_r.rd_oe;
   assign go_o = st_r.go_drv;
   assign go_oe = st_r.go_oe;
   assign dout = st_r.dout;
   assign result_half_marker = st_r.marker;
   assign busy = st_r.busy;

endmodule : cfr_regctl

/* hdl/cfr_pkg.sv */
/*
 * Constants for the cascadable filter register control block: register
 * addresses, configuration field positions, reset values and cycle counts.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cfr_pkg;

   localparam int CFR_TAPS = 32;

   // Seven-bit address map of the static-RAM-like port
   localparam logic [6:0] CFR_ADR_UCR0 = 7'h00;
   localparam logic [6:0] CFR_ADR_CCR0 = 7'h20;
   localparam logic [6:0] CFR_ADR_SCR = 7'h40;
   localparam logic [6:0] CFR_ADR_ACR = 7'h42;
   localparam logic [6:0] CFR_ADR_TCR = 7'h44;
   localparam logic [6:0] CFR_ADR_DIR = 7'h48;
   localparam logic [6:0] CFR_ADR_DOL = 7'h4a;
   localparam logic [6:0] CFR_ADR_DOH = 7'h4b;
   // Upper registers are shadowed from 80 up to 127
   localparam logic [6:0] CFR_ADR_SHADOW_MASK = 7'h4f;

   // Static configuration fields
   localparam int CFR_SCR_FAST = 10;
   localparam int CFR_SCR_SIZE_LO = 8;
   localparam int CFR_SCR_SEL_LO = 4;
   localparam int CFR_SCR_CONT = 2;
   localparam int CFR_SCR_SRC = 1;
   localparam int CFR_SCR_MASTER = 0;
   localparam logic [15:0] CFR_SCR_RESET = 16'h0320;

   // Active control / status fields
   localparam int CFR_ACR_SWAP = 0;
   localparam int CFR_ACR_ERR_LO = 1;

   // Test control: full-word examine bit
   localparam int CFR_TCR_FULL = 2;

   // Minimum input interval in cycles, indexed by coefficient size code
   localparam logic [3:0] CFR_IVL_4 = 4'h2;
   localparam logic [3:0] CFR_IVL_8 = 4'h4;
   localparam logic [3:0] CFR_IVL_12 = 4'h6;
   localparam logic [3:0] CFR_IVL_16 = 4'h8;
   // Low half lasts one cycle in fast output mode
   localparam logic [3:0] CFR_FAST_LOW = 4'h1;

   // Field start in the zero-padded accumulator, per selection code;
   // the pad adds one, so field [7-30] starts at padded bit 8
   localparam logic [5:0] CFR_POS_00 = 6'h08;
   localparam logic [5:0] CFR_POS_01 = 6'h0c;
   localparam logic [5:0] CFR_POS_10 = 6'h10;
   localparam logic [5:0] CFR_POS_11 = 6'h15;
   localparam logic [5:0] CFR_POS_FULL = 6'h00;

   typedef enum logic [1:0] {
      CFR_OUT_IDLE,
      CFR_OUT_LOW,
      CFR_OUT_HIGH
   } cfr_out_t;

endpackage : cfr_pkg

/* hdl/cfr_mac.sv */
/*
 * Thirty-two tap multiply-accumulate array: combinational sum of active
 * coefficient times sample history, coefficients narrowed to the chosen
 * width. Assumes the caller registers the result.
 */
module cfr_mac
   import cfr_pkg::*;
(
   input wire logic [CFR_TAPS-1:0][15:0] coef,
   input wire logic [CFR_TAPS-1:0][15:0] hist,
   input wire logic [1:0] csize,
   output logic signed [36:0] acc
);

   logic signed [CFR_TAPS-1:0][31:0] prod;

   // Only the low bits of the width are used, upper ones ignored
   function automatic logic signed [15:0] narrow(input logic [15:0] c,
                                                 input logic [1:0] sz);
      case (sz)
         2'b00: narrow = {{12{c[3]}}, c[3:0]};
         2'b01: narrow = {{8{c[7]}}, c[7:0]};
         2'b10: narrow = {{4{c[11]}}, c[11:0]};
         default: narrow = c;
      endcase
   endfunction : narrow

   // Entry 0 drives the tap nearest the output (newest sample)
   genvar k;
   generate
      for (k = 0; k < CFR_TAPS; k++) begin : g_tap
         assign prod[k] = narrow(coef[k], csize) *
                          $signed(hist[k]); // see [R2] see [R15]
      end
   endgenerate

   always_comb begin
      acc = '0;
      for (int i = 0; i < CFR_TAPS; i++) begin
         acc = acc + 37'(signed'(prod[i]));
      end
   end

endmodule : cfr_mac

/* sim/cfr_regctl_sva.sv */
/* Port checker for cfr_regctl.
   Assumes one clock and the synchronous active-low reset. */
module cfr_chk (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic ce_n,
   input wire logic w_n,
   input wire logic [6:0] adr,
   input wire logic [15:0] d_o,
   input wire logic d_oe,
   input wire logic go_o,
   input wire logic go_oe,
   input wire logic [11:0] dout,
   input wire logic result_half_marker,
   input wire logic busy
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire logic rd = !ce_n && !cs_n && w_n;

   a_read_drives: assert property (rd |=> d_oe)
      else $error("read not driven");
   a_idle_quiet: assert property (!rd |=> !d_oe)
      else $error("bus driven without read");
   a_input_hidden: assert property (rd && adr == 7'h48 |=> d_o == 16'h0000)
      else $error("input word readable");
   a_busy_single: assert property (busy |=> !busy)
      else $error("busy longer than one cycle");
   a_go_width: assert property ($rose(go_o) |=> go_o ##1 !go_o)
      else $error("strobe width wrong");
   a_go_driven: assert property (go_o |-> go_oe)
      else $error("strobe high while undriven");
   a_high_holds: assert property (result_half_marker &&
      $past(result_half_marker) |-> $stable(dout))
      else $error("high half moved");
   a_low_short: assert property ($fell(result_half_marker) |->
      ##[1:4] result_half_marker)
      else $error("low half too long");
   c_swap: cover property (busy);
   c_result: cover property ($rose(result_half_marker));
   c_master: cover property ($rose(go_o));
endmodule : cfr_chk

bind cfr_regctl cfr_chk chk (.clock, .rst_n, .cs_n, .ce_n, .w_n, .adr,
   .d_o, .d_oe, .go_o, .go_oe, .dout, .result_half_marker, .busy);

/* sim/cfr_host.sv */
/* Host processor model: static-RAM-like register cycles.
   Assumes the caller starts no task before reset is released. */
module cfr_host (
   input wire logic clock,
   input wire logic [15:0] d_o,
   output logic cs_n,
   output logic ce_n,
   output logic w_n,
   output logic [6:0] adr,
   output logic [15:0] d_i
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {cs_n, ce_n, w_n} = 3'h7;
      adr = 7'h00;
      d_i = 16'h0000;
   end
   // Write commits on the edge after ce_n rises
   task automatic wr(input logic [6:0] a, input logic [15:0] v);
      @(posedge clock);
      {cs_n, ce_n, w_n} <= 3'h0;
      adr <= a;
      d_i <= v;
      @(posedge clock);
      {cs_n, ce_n, w_n} <= 3'h7;
      // Released bus must not keep showing the old word
      d_i <= ~v;
   endtask : wr
   task automatic rd(input logic [6:0] a, output logic [15:0] v);
      @(posedge clock);
      {cs_n, ce_n, w_n} <= 3'h1;
      adr <= a;
      @(posedge clock);
      @(posedge clock);
      {cs_n, ce_n, w_n} <= 3'h7;
      #1 v = d_o;
   endtask : rd
endmodule : cfr_host

/* sim/tb.sv */
/* Self-checking bench for cfr_regctl with the host model.
   Assumes first device of a cascade: cascade input grounded. */
module tb;
   import cfr_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic w; logic [6:0] a; logic [15:0] v;} cfr_row_t;
   typedef struct packed {logic [15:0] s; logic [3:0] n; logic [23:0] r;}
      cfr_run_t;
   logic clock, rst_n, cs_n, ce_n, w_n, d_oe, go_i, go_o, go_oe, mk, busy;
   logic [6:0] adr;
   logic [15:0] d_i, d_o, din, v;
   logic [11:0] dout;
   int failures, compares, k;
   cfr_row_t rows[12] = '{{1'b0, 7'h40, 16'h0320}, {1'b0, 7'h42, 16'h0000},
      {1'b1, 7'h05, 16'ha5a5}, {1'b1, 7'h25, 16'h5a5a},
      {1'b0, 7'h05, 16'ha5a5}, {1'b0, 7'h25, 16'h5a5a},
      {1'b1, 7'h41, 16'hffff}, {1'b0, 7'h41, 16'h0000},
      {1'b0, 7'h70, 16'h0320}, {1'b1, 7'h48, 16'h1234},
      {1'b0, 7'h48, 16'h0000}, {1'b0, 7'h44, 16'h0000}};
   // Master from input word: size 4 normal/fast, size 8, then continuous
   cfr_run_t runs[4] = '{{16'h0003, 4'h1, 24'hfffffe},
      {16'h0403, 4'h1, 24'hfffffe}, {16'h0103, 4'h2, 24'h00001e},
      {16'h0507, 4'h1, 24'h00001e}};

   cfr_regctl uut (.clock, .rst_n, .cs_n, .ce_n, .w_n, .adr, .d_i, .d_o,
      .d_oe, .go_i, .go_o, .go_oe, .din, .cascade_input_pins(12'h000),
      .dout, .result_half_marker(mk), .busy);
   cfr_host host (.clock, .d_o, .cs_n, .ce_n, .w_n, .adr, .d_i);

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   initial begin
      #125000;
      failures++;
      conclude();
   end

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic conclude();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : conclude
   // One output cycle: low half length, both halves, result words
   task automatic cyc(input logic [3:0] len, input logic [23:0] r);
      logic [11:0] lo;
      int n;
      n = 0;
      #1;
      while (mk !== 1'b0 && n < 60) begin
         @(posedge clock);
         #1 n++;
      end
      n = 0;
      while (mk === 1'b0 && n < 60) begin
         lo = dout;
         @(posedge clock);
         #1 n++;
      end
      if (len != 4'h0) chk(16'(n), {12'h000, len});
      chk({4'h0, lo}, {4'h0, r[11:0]});
      chk({4'h0, dout}, {4'h0, r[23:12]});
      host.rd(CFR_ADR_DOL, v);
      chk(v, r[15:0]);
      host.rd(CFR_ADR_DOH, v);
      chk(v, {{8{r[23]}}, r[23:16]});
   endtask : cyc

   initial begin
      rst_n = 1'b0;
      go_i = 1'b0;
      din = 16'h0100;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].w) host.wr(rows[i].a, rows[i].v);
         else begin
            host.rd(rows[i].a, v);
            chk(v, rows[i].v);
         end
      end
      host.wr(CFR_ADR_ACR, 16'h0001);
      k = 0;
      while (busy !== 1'b1 && k < 10) begin
         @(posedge clock);
         #1 k++;
      end
      chk(16'(k < 10), 16'h0001);
      host.rd(7'h05, v);
      chk(v, 16'h5a5a);
      host.rd(7'h25, v);
      chk(v, 16'ha5a5);
      host.rd(CFR_ADR_ACR, v);
      chk(v, 16'h0000);
      // Whole coefficient word is used at the reset 16-bit size
      host.wr(CFR_ADR_CCR0, 16'h00f1);
      @(posedge clock);
      go_i <= 1'b1;
      @(posedge clock);
      go_i <= 1'b0;
      cyc(4'h0, 24'h000002);
      foreach (runs[i]) begin
         host.wr(CFR_ADR_SCR, runs[i].s);
         repeat (20) @(posedge clock);
         host.wr(CFR_ADR_DIR, 16'hff00);
         cyc(runs[i].n, runs[i].r);
         chk({15'h0000, go_oe}, 16'h0001);
      end
      host.rd(CFR_ADR_UCR0, v);
      chk(v, 16'h00f1);
      conclude();
   end
endmodule : tb
